// File: tsa_pkg.sv
`default_nettype none
package tsa_pkg;
  // --------------------------------------------------------------
  // Timebase
  // --------------------------------------------------------------
  localparam int SYS_KHZ = 200000;
  localparam int CONV_MS = 125;
  localparam int PERIOD_RUN_MS = 250;
  localparam int PERIOD_FAST_MS = 125;
  localparam int CYC_W = 26;
  // --------------------------------------------------------------
  // Addresses and command codes
  // --------------------------------------------------------------
  localparam logic [3:0] DEV_ADDR_HI = 4'h9;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [7:0] CMD_RD_LOCAL = 8'h00;
  localparam logic [7:0] CMD_RD_REMOTE = 8'h01;
  localparam logic [7:0] CMD_RD_FLAGS = 8'h02;
  localparam logic [7:0] CMD_RD_SETUP = 8'h03;
  localparam logic [7:0] CMD_RD_LLIM = 8'h05;
  localparam logic [7:0] CMD_RD_RLIM = 8'h07;
  localparam logic [7:0] CMD_WR_SETUP = 8'h09;
  localparam logic [7:0] CMD_WR_LLIM = 8'h0b;
  localparam logic [7:0] CMD_WR_RLIM = 8'h0d;
  localparam logic [7:0] CMD_ONE_SHOT = 8'h0f;
  localparam logic [7:0] CMD_RD_MFR = 8'hfe;
  // --------------------------------------------------------------
  // Reset values and field positions
  // --------------------------------------------------------------
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h10;
  localparam logic [7:0] SETUP_WMASK = 8'hf0;
  localparam logic [7:0] LLIM_RST = 8'h46;
  localparam logic [7:0] RLIM_RST = 8'h78;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] FAULT_TEMP = 8'hff;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int SB_MASK = 7;
  localparam int SB_STBY = 6;
  localparam int SB_EXT = 5;
  localparam int SB_QUEUE = 4;
  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef struct packed {
    logic [7:0] localT;
    logic [7:0] remoteT;
    logic diodeOpen;
  } tsa_meas_s;
  typedef struct packed {
    logic localOk;
    tsa_meas_s meas;
  } tsa_result_s;
  typedef enum logic [7:0] {
    L_IDLE = 8'h01, L_ADDR = 8'h02, L_AACK = 8'h04, L_RX = 8'h08,
    L_RACK = 8'h10, L_TX = 8'h20, L_MACK = 8'h40, L_WAIT = 8'h80
  } tsa_link_e;
  typedef enum logic [1:0] {C_IDLE = 2'b01, C_RUN = 2'b10} tsa_conv_e;
endpackage : tsa_pkg
`default_nettype wire

// File: tsa_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tsa_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,  // Sampling clock
  input wire logic nrst,  // Async reset, active low
  input wire logic [W-1:0] din,  // Asynchronous levels
  output logic [W-1:0] dout  // Settled levels
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // A change counts only once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= (s2 & s3) | (dout & (s2 | s3));
    end
  end
endmodule : tsa_pin_sync
`default_nettype wire

// File: tsa_alarm_ctrl.sv
// How it works
// - Alert cleared by response but still over limit returns after next conversion.
// - Writing either limit releases a standing alert once no reading is at or above its limit.
// - Alert pin only pulls low or releases; never drives high.
// - Alert response read returns own slave address when alert pending.
// - Arbitration lost on response byte: no more drive, alert kept low.
// - Setup bit 7 masks the alert; resets to 0.
// - Setup bit 6 selects standby, stopping autonomous conversions; resets to 0.
// - Setup bit 5 converts remote only at 8 Hz; resets to 0.
// - Setup bit 4 needs two faulting conversions; resets to 1, low bits zero.
// - Flag bit 7 shows a conversion in progress.
// - Flag bit 6 local over limit, cleared by reset or flag read.
// - Flag bit 4 remote over limit, cleared by reset or flag read.
// - Flag bit 2 diode fault, read clears only once fault is gone.
// - Flag read clears the over-limit flags and alert only when no longer over limit.
// - Pointer is 8 bits, resets to zero so first read gives local.
// - One-shot in standby runs one conversion then returns to standby.
// - One-shot ignored while one runs or in autonomous mode.
// - Answers 1001 plus three variant bits, and the response address.
// - After reset alert released and conversions start at 4 Hz.
// - Limits reset to +70 and +120 degrees.
// - Reading equal to or above limit flags the channel and alerts.
// - Alert latched until flag read after fault, a won response or a limit write.
// - Diode fault sets only its flag and forces remote reading all ones.
`timescale 1ns/1ps
`default_nettype none
module tsa_alarm_ctrl
  import tsa_pkg::*;
#(
  parameter logic [2:0] ADDR_LOW = 3'h0,
  parameter logic [7:0] MFR_ID = 8'h5a,  // Arbitrary value
  parameter int P_CONV_CYC = CONV_MS * SYS_KHZ,
  parameter int P_RUN_CYC = PERIOD_RUN_MS * SYS_KHZ,
  parameter int P_FAST_CYC = PERIOD_FAST_MS * SYS_KHZ
) (
  input wire logic clk_sys,  // Conversion timebase
  input wire logic nrst,  // Power-on reset
  input wire logic clkLink,  // Bus sampling clock
  input wire logic sclIn,  // Bus clock pin
  input wire logic sdaIn,  // Bus data pin, in
  output logic sdaOut,  // Bus data pin, out
  output logic sdaOe,  // Bus data pin, pull low
  output logic alertOut,  // Alert pin, out
  output logic alertOe,  // Alert pin, pull low
  input wire tsa_pkg::tsa_meas_s meas  // Converter readings
);
  // --------------------------------------------------------------
  // Conversion sequencer (clk_sys)
  // --------------------------------------------------------------
  tsa_conv_e cState;
  logic [CYC_W-1:0] convCnt;
  logic [CYC_W-1:0] perCnt;
  logic oneShot;
  logic resTgl;
  tsa_result_s result;
  logic localOk;
  logic [7:0] setup;
  logic ssTgl;
  logic [2:0] sysIn;
  logic ssQ;
  logic stby;
  logic extOnly;
  logic ssEv;
  logic convStart;
  logic convDone;
  assign stby = sysIn[2];
  assign extOnly = sysIn[1];
  assign ssEv = sysIn[0] ^ ssQ;
  tsa_pin_sync #(.W(3)) uSysSync (
    .clk(clk_sys),
    .nrst(nrst),
    .din({setup[SB_STBY], setup[SB_EXT], ssTgl}),
    .dout(sysIn)
  );
  // One-shot counts only in standby with nothing running
  assign convStart = (cState == C_IDLE) &&
                     ((!stby && perCnt == '0) || (stby && ssEv));
  assign convDone = (cState == C_RUN) && (convCnt == '0);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      perCnt <= '0;
    end else if (stby) begin
      perCnt <= '0;
    end else if (perCnt == '0) begin
      perCnt <= extOnly ? CYC_W'(P_FAST_CYC - 1) : CYC_W'(P_RUN_CYC - 1);
    end else begin
      perCnt <= perCnt - 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cState <= C_IDLE;
      convCnt <= '0;
      oneShot <= 1'b0;
      localOk <= 1'b0;
    end else begin
      case (cState)
        C_IDLE: begin
          if (convStart) begin
            cState <= C_RUN;
            // One cycle short, so a fast-mode period never lands on a running conversion
            convCnt <= CYC_W'(P_CONV_CYC - 2);
            oneShot <= stby;
            localOk <= !extOnly;
          end
        end
        C_RUN: begin
          convCnt <= convCnt - 1'b1;
          // Standby during a run truncates it; old data stays
          if (convDone || (stby && !oneShot)) begin
            cState <= C_IDLE;
            oneShot <= 1'b0;
          end
        end
        default: cState <= C_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ssQ <= 1'b0;
    end else begin
      ssQ <= sysIn[0];
    end
  end
  // Result is held for a whole conversion, so the link may read it after the toggle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      result <= '0;
      resTgl <= 1'b0;
    end else if (convDone) begin
      result <= {localOk, meas};
      resTgl <= ~resTgl;
    end
  end
  // --------------------------------------------------------------
  // Bus front end (clkLink)
  // --------------------------------------------------------------
  logic [3:0] lnkIn;
  logic sclQ;
  logic sdaQ;
  logic resQ;
  logic scl;
  logic sda;
  logic busy;
  logic convEv;
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;
  assign {scl, sda, busy} = lnkIn[3:1];
  tsa_pin_sync #(.W(4)) uLinkSync (
    .clk(clkLink),
    .nrst(nrst),
    .din({sclIn, sdaIn, cState == C_RUN, resTgl}),
    .dout(lnkIn)
  );
  assign convEv = lnkIn[0] ^ resQ;
  assign sclRise = scl && !sclQ;
  assign sclFall = !scl && sclQ;
  assign startEv = scl && sclQ && sdaQ && !sda;
  assign stopEv = scl && sclQ && !sdaQ && sda;
  always_ff @(posedge clkLink or negedge nrst) begin
    if (!nrst) begin
      sclQ <= 1'b0;
      sdaQ <= 1'b0;
      resQ <= 1'b0;
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
      resQ <= lnkIn[0];
    end
  end
  // --------------------------------------------------------------
  // Bus slave state machine
  // --------------------------------------------------------------
  tsa_link_e st;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] txSh;
  logic isRead;
  logic isAra;
  logic dataPhase;
  logic txFlags;
  logic pendClr;
  logic alertLatch;
  logic [7:0] ptr;
  logic [7:0] readByte;
  logic [6:0] ownAddr;
  logic hitDev;
  logic hitAra;
  logic rxDone;
  logic txDone;
  logic lostArb;
  assign ownAddr = {DEV_ADDR_HI, ADDR_LOW};
  assign hitDev = shiftIn[7:1] == ownAddr;
  assign hitAra = shiftIn[7:1] == ARA_ADDR && shiftIn[0] && alertLatch;
  assign rxDone = (st == L_RX) && sclFall && bitCnt == BITS_PER_BYTE;
  assign txDone = (st == L_TX) && sclFall && bitCnt == BITS_PER_BYTE - 1'b1;
  // Released one while the wire reads low: a lower address is talking
  assign lostArb = (st == L_TX) && sclRise && isAra && txSh[7] && !sda;
  always_ff @(posedge clkLink or negedge nrst) begin
    if (!nrst) begin
      st <= L_IDLE;
      bitCnt <= BIT_CNT_RST;
      shiftIn <= '0;
      txSh <= '0;
      isRead <= 1'b0;
      isAra <= 1'b0;
      dataPhase <= 1'b0;
      txFlags <= 1'b0;
    end else if (startEv) begin
      st <= L_ADDR;
      bitCnt <= BIT_CNT_RST;
      dataPhase <= 1'b0;
    end else if (stopEv) begin
      st <= L_IDLE;
    end else begin
      case (st)
        L_ADDR, L_RX: begin
          if (sclRise) begin
            shiftIn <= {shiftIn[6:0], sda};
            bitCnt <= bitCnt + 1'b1;
          end
          if (sclFall && bitCnt == BITS_PER_BYTE) begin
            if (st == L_RX) begin
              st <= L_RACK;
              dataPhase <= 1'b1;
            end else if (hitDev || hitAra) begin
              st <= L_AACK;
              isRead <= shiftIn[0];
              isAra <= !hitDev;
            end else begin
              st <= L_WAIT;
            end
          end
        end
        L_AACK: begin
          if (sclFall) begin
            bitCnt <= BIT_CNT_RST;
            st <= isRead ? L_TX : L_RX;
            txSh <= isAra ? {ownAddr, 1'b0} : readByte;
            txFlags <= !isAra && ptr == CMD_RD_FLAGS;
          end
        end
        L_RACK: begin
          if (sclFall) begin
            bitCnt <= BIT_CNT_RST;
            st <= L_RX;
          end
        end
        L_TX: begin
          if (lostArb) begin
            st <= L_WAIT;
          end else if (sclFall) begin
            txSh <= {txSh[6:0], 1'b0};
            bitCnt <= bitCnt + 1'b1;
            if (txDone) begin
              st <= L_MACK;
            end
          end
        end
        L_MACK: begin
          if (sclFall) begin
            st <= L_WAIT;
          end
        end
        L_IDLE, L_WAIT: st <= st;
        default: st <= L_IDLE;
      endcase
    end
  end
  // Open drain: the data bit is always low, only the enable moves
  assign sdaOut = 1'b0;
  assign sdaOe = (st == L_AACK) || (st == L_RACK) || (st == L_TX && !txSh[7]);
  // --------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------
  logic [7:0] limLoc;
  logic [7:0] limRem;
  logic [7:0] tempLoc;
  logic [7:0] tempRem;
  logic overLoc;
  logic overRem;
  logic openFlag;
  logic openNow;
  logic qLoc;
  logic qRem;
  logic limWr;
  logic overNow;
  logic locFault;
  logic remFault;
  logic locTrip;
  logic remTrip;
  logic flagClr;
  logic araDone;
  logic limClr;
  always_ff @(posedge clkLink or negedge nrst) begin
    if (!nrst) begin
      ptr <= PTR_RST;
      ssTgl <= 1'b0;
    end else if (rxDone && !dataPhase) begin
      ptr <= shiftIn;
      if (shiftIn == CMD_ONE_SHOT) begin
        ssTgl <= ~ssTgl;
      end
    end
  end
  always_ff @(posedge clkLink or negedge nrst) begin
    if (!nrst) begin
      setup <= SETUP_RST;
      limLoc <= LLIM_RST;
      limRem <= RLIM_RST;
      limWr <= 1'b0;
    end else begin
      limWr <= 1'b0;
      if (rxDone && dataPhase) begin
        case (ptr)
          CMD_WR_SETUP: setup <= shiftIn & SETUP_WMASK;
          CMD_WR_LLIM: begin
            limLoc <= shiftIn;
            limWr <= 1'b1;
          end
          CMD_WR_RLIM: begin
            limRem <= shiftIn;
            limWr <= 1'b1;
          end
          default: limWr <= 1'b0;
        endcase
      end
    end
  end
  always_comb begin
    case (ptr)
      CMD_RD_LOCAL: readByte = tempLoc;
      CMD_RD_REMOTE: readByte = tempRem;
      CMD_RD_FLAGS: readByte = {busy, overLoc, 1'b0, overRem, 1'b0, openFlag, 2'b00};
      CMD_RD_SETUP: readByte = setup;
      CMD_RD_LLIM: readByte = limLoc;
      CMD_RD_RLIM: readByte = limRem;
      CMD_RD_MFR: readByte = MFR_ID;
      default: readByte = 8'h00;
    endcase
  end
  // --------------------------------------------------------------
  // Limit check, fault queue and alert latch
  // --------------------------------------------------------------
  assign locFault = result.localOk && result.meas.localT >= limLoc;
  assign remFault = !result.meas.diodeOpen && result.meas.remoteT >= limRem;
  assign locTrip = convEv && locFault && (!setup[SB_QUEUE] || qLoc);
  assign remTrip = convEv && remFault && (!setup[SB_QUEUE] || qRem);
  assign overNow = tempLoc >= limLoc || (!openNow && tempRem >= limRem);
  assign flagClr = stopEv && pendClr;
  assign araDone = txDone && isAra;
  assign limClr = limWr && !overNow;
  always_ff @(posedge clkLink or negedge nrst) begin
    if (!nrst) begin
      tempLoc <= TEMP_RST;
      tempRem <= TEMP_RST;
      openNow <= 1'b0;
      qLoc <= 1'b0;
      qRem <= 1'b0;
    end else if (convEv) begin
      if (result.localOk) begin
        tempLoc <= result.meas.localT;
      end
      tempRem <= result.meas.diodeOpen ? FAULT_TEMP : result.meas.remoteT;
      openNow <= result.meas.diodeOpen;
      qLoc <= locFault;
      qRem <= remFault;
    end
  end
  // A flag read only clears once the stop closes the transfer
  always_ff @(posedge clkLink or negedge nrst) begin
    if (!nrst) begin
      pendClr <= 1'b0;
    end else if (startEv || stopEv) begin
      pendClr <= 1'b0;
    end else if (txDone && txFlags) begin
      pendClr <= 1'b1;
    end
  end
  // Clears first, sets last, so a fault in the same cycle is kept
  always_ff @(posedge clkLink or negedge nrst) begin
    if (!nrst) begin
      overLoc <= 1'b0;
      overRem <= 1'b0;
      openFlag <= 1'b0;
    end else begin
      if (flagClr && !overNow) begin
        overLoc <= 1'b0;
        overRem <= 1'b0;
      end
      if (flagClr && !openNow) begin
        openFlag <= 1'b0;
      end
      if (locTrip) begin
        overLoc <= 1'b1;
      end
      if (remTrip) begin
        overRem <= 1'b1;
      end
      if (convEv && result.meas.diodeOpen) begin
        openFlag <= 1'b1;
      end
    end
  end
  always_ff @(posedge clkLink or negedge nrst) begin
    if (!nrst) begin
      alertLatch <= 1'b0;
    end else begin
      if ((flagClr && !overNow) || araDone || limClr) begin
        alertLatch <= 1'b0;
      end
      if ((locTrip || remTrip) && !setup[SB_MASK]) begin
        alertLatch <= 1'b1;
      end
    end
  end
  // A lost arbitration leaves the latch set, so the line stays low
  assign alertOut = 1'b0;
  assign alertOe = alertLatch && !setup[SB_MASK];
  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_pins_open_drain: assert property (@(posedge clkLink) disable iff (!nrst)
    !alertOut && !sdaOut) else $error("pin driven high");
  a_mask_blocks: assert property (@(posedge clkLink) disable iff (!nrst)
    setup[SB_MASK] |-> !alertOe) else $error("masked alert driven");
  a_ara_clears: assert property (@(posedge clkLink) disable iff (!nrst)
    araDone && !locTrip && !remTrip |=> !alertLatch) else $error("response kept alert");
  a_lost_holds: assert property (@(posedge clkLink) disable iff (!nrst)
    lostArb && alertLatch |=> (st == L_WAIT && alertLatch) [*2]) else $error("lost arb dropped");
  a_flag_clear_stop: assert property (@(posedge clkLink) disable iff (!nrst)
    $fell(overLoc) |-> $past(flagClr)) else $error("flag cleared off stop");
  a_open_no_alert: assert property (@(posedge clkLink) disable iff (!nrst)
    convEv && !locTrip && !remTrip && !limWr && !flagClr && !araDone
    |=> alertLatch == $past(alertLatch)) else $error("diode fault moved alert");
  a_trip_sets: assert property (@(posedge clkLink) disable iff (!nrst)
    (locTrip || remTrip) && !setup[SB_MASK] |=> alertLatch && alertOe)
    else $error("trip missed");
  a_period_kept: assert property (@(posedge clk_sys) disable iff (!nrst)
    !stby && !oneShot && perCnt == '0 |-> convStart) else $error("periodic start missed");
  a_standby_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    cState == C_IDLE && stby && !ssEv |=> cState == C_IDLE) else $error("standby ran");
  a_oneshot_ignored: assert property (@(posedge clk_sys) disable iff (!nrst)
    cState == C_IDLE && !stby && perCnt != '0 && ssEv |=> cState == C_IDLE)
    else $error("one-shot in run");
  a_oneshot_runs: assert property (@(posedge clk_sys) disable iff (!nrst)
    cState == C_IDLE && stby && ssEv |=> cState == C_RUN && oneShot) else $error("one-shot lost");
  c_ara_win: cover property (@(posedge clkLink) disable iff (!nrst) araDone);
  c_flag_clear: cover property (@(posedge clkLink) disable iff (!nrst) flagClr && !overNow);
  c_lost_arb: cover property (@(posedge clkLink) disable iff (!nrst) lostArb);
  c_oneshot: cover property (@(posedge clk_sys) disable iff (!nrst) convStart && stby);
endmodule : tsa_alarm_ctrl
`default_nettype wire

// File: tsa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsa_host_model (
  input wire logic sdaOe,  // Device pulls data low
  output logic scl,  // Bus clock wire
  output logic sda  // Bus data wire
);
  int lowNs = 120;
  logic pull = 1'b0;
  // ----------------------------------------
  // Open-drain data wire, pulled up when released
  // ----------------------------------------
  assign sda = !(pull || sdaOe);
  initial scl = 1'b1;
  // Data moves only mid-low, so the synchronised view never shows a false start
  task automatic bitIo(input logic b, output logic r);
    #80;
    pull = !b;
    #lowNs;
    scl = 1'b1;
    #150;
    r = sda;
    scl = 1'b0;
  endtask : bitIo
  task automatic start();
    #80;
    pull = 1'b0;
    #lowNs;
    scl = 1'b1;
    #150;
    pull = 1'b1;
    #150;
    scl = 1'b0;
  endtask : start
  task automatic stop();
    #80;
    pull = 1'b1;
    #lowNs;
    scl = 1'b1;
    #150;
    pull = 1'b0;
    #400;
  endtask : stop
  task automatic byteIo(input logic [7:0] d, input logic mAck,
                        output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], q[i]);
    end
    bitIo(mAck, r);
    ack = !r;
  endtask : byteIo
endmodule : tsa_host_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tsa_pkg::*;
  localparam logic [2:0] ADDR_LO = 3'h5;
  localparam logic [6:0] DEV = {4'h9, ADDR_LO};
  localparam int PER = 400;
  logic clk_sys;
  logic clkLink;
  logic nrst;
  logic scl;
  logic sda;
  logic sdaOut;
  logic sdaOe;
  logic alertOut;
  logic alertOe;
  tsa_meas_s meas;
  int n_fail = 0;
  int compares = 0;
  tsa_alarm_ctrl #(.ADDR_LOW(ADDR_LO), .P_CONV_CYC(200), .P_RUN_CYC(PER), .P_FAST_CYC(200))
    tsa_alarm_ctrl_i (.clk_sys(clk_sys), .nrst(nrst), .clkLink(clkLink), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .alertOut(alertOut), .alertOe(alertOe),
    .meas(meas));
  tsa_host_model tsa_host_model_i (.sdaOe(sdaOe), .scl(scl), .sda(sda));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = !clk_sys;
  end
  initial begin
    clkLink = 1'b0;
    #7.3;
    forever #15 clkLink = !clkLink;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic expAl(input logic e);
    check({7'h0, alertOe}, {7'h0, e});
  endtask : expAl
  task automatic wb(input logic [7:0] d);
    logic [7:0] q;
    logic ack;
    tsa_host_model_i.byteIo(d, 1'b1, q, ack);
    check({7'h0, ack}, 8'h01);
  endtask : wb
  task automatic wrReg(input logic [7:0] cmd, input logic [7:0] d, input bit hasData);
    tsa_host_model_i.start();
    wb({DEV, 1'b0});
    wb(cmd);
    if (hasData) begin
      wb(d);
    end
    tsa_host_model_i.stop();
  endtask : wrReg
  task automatic rx(input logic [6:0] a, output logic [7:0] q);
    logic ack;
    tsa_host_model_i.start();
    wb({a, 1'b1});
    tsa_host_model_i.byteIo(8'hff, 1'b1, q, ack);
    tsa_host_model_i.stop();
  endtask : rx
  task automatic expRd(input logic [7:0] cmd, input logic [7:0] exp, input logic [7:0] msk);
    logic [7:0] q;
    wrReg(cmd, 8'h00, 1'b0);
    rx(DEV, q);
    check(q & msk, exp);
  endtask : expRd
  task automatic setMeas(input logic [7:0] l, input logic [7:0] r, input logic o);
    @(posedge clk_sys);
    #1;
    meas = {l, r, o};
  endtask : setMeas
  task automatic waitPer(input int n);
    repeat (n * PER) @(posedge clk_sys);
    #1;
  endtask : waitPer
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic resetValues();
    logic [7:0] q;
    expAl(1'b0);
    check({6'h0, alertOut, sdaOut}, 8'h00);
    rx(DEV, q);
    check(q, 8'h19);
    expRd(CMD_RD_SETUP, 8'h10, 8'hff);
    expRd(CMD_RD_LLIM, 8'h46, 8'hff);
    expRd(CMD_RD_RLIM, 8'h78, 8'hff);
    expRd(CMD_RD_FLAGS, 8'h00, 8'h7f);
    expRd(8'h04, 8'h00, 8'hff);
  endtask : resetValues
  task automatic overTemp();
    setMeas(8'h46, 8'h20, 1'b0);
    waitPer(3);
    expAl(1'b1);
    check({7'h0, alertOut}, 8'h00);
    expRd(CMD_RD_FLAGS, 8'h40, 8'h7f);
    expAl(1'b1);
    wrReg(CMD_WR_SETUP, 8'h90, 1'b1);
    expAl(1'b0);
    wrReg(CMD_WR_SETUP, 8'h10, 1'b1);
    expAl(1'b1);
  endtask : overTemp
  task automatic araTest();
    logic [7:0] q;
    logic ack;
    // Standby keeps conversions from re-arming the latch during the check
    wrReg(CMD_WR_SETUP, 8'h40, 1'b1);
    // Host drives zeros, acting as a lower address that wins the byte
    tsa_host_model_i.start();
    wb({ARA_ADDR, 1'b1});
    tsa_host_model_i.byteIo(8'h00, 1'b1, q, ack);
    tsa_host_model_i.stop();
    expAl(1'b1);
    rx(ARA_ADDR, q);
    check(q, {DEV, 1'b0});
    expAl(1'b0);
    wrReg(CMD_ONE_SHOT, 8'h00, 1'b0);
    waitPer(1);
    expAl(1'b1);
  endtask : araTest
  task automatic limitTest();
    wrReg(CMD_WR_LLIM, 8'h47, 1'b1);
    expAl(1'b0);
    expRd(CMD_RD_LLIM, 8'h47, 8'hff);
    expRd(CMD_RD_FLAGS, 8'h40, 8'hff);
    expRd(CMD_RD_FLAGS, 8'h00, 8'hff);
  endtask : limitTest
  task automatic standbyTest();
    setMeas(8'h21, 8'h20, 1'b0);
    waitPer(3);
    expRd(CMD_RD_LOCAL, 8'h46, 8'hff);
    wrReg(CMD_ONE_SHOT, 8'h00, 1'b0);
    waitPer(1);
    expRd(CMD_RD_LOCAL, 8'h21, 8'hff);
  endtask : standbyTest
  task automatic diodeTest();
    wrReg(CMD_WR_SETUP, 8'h0f, 1'b1);
    expRd(CMD_RD_SETUP, 8'h00, 8'hff);
    setMeas(8'h21, 8'h20, 1'b1);
    waitPer(2);
    expRd(CMD_RD_REMOTE, 8'hff, 8'hff);
    expAl(1'b0);
    expRd(CMD_RD_FLAGS, 8'h04, 8'h7f);
    expRd(CMD_RD_FLAGS, 8'h04, 8'h7f);
    setMeas(8'h21, 8'h20, 1'b0);
    waitPer(2);
    expRd(CMD_RD_FLAGS, 8'h04, 8'h7f);
    expRd(CMD_RD_FLAGS, 8'h00, 8'h7f);
  endtask : diodeTest
  task automatic extTest();
    wrReg(CMD_WR_SETUP, 8'h20, 1'b1);
    setMeas(8'h30, 8'h78, 1'b0);
    waitPer(2);
    expRd(CMD_RD_LOCAL, 8'h21, 8'hff);
    expRd(CMD_RD_REMOTE, 8'h78, 8'hff);
    expRd(CMD_RD_FLAGS, 8'h10, 8'h7f);
    expAl(1'b1);
  endtask : extTest
  task automatic final_report();
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    nrst = 1'b0;
    meas = {8'h19, 8'h20, 1'b0};
    repeat (8) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    repeat (20) @(posedge clk_sys);
    resetValues();
    overTemp();
    araTest();
    limitTest();
    standbyTest();
    diodeTest();
    extTest();
    final_report();
  end
  initial begin
    #500_000;
    n_fail++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
